// [logic/crs_pkg.sv]
// Shared constants and types for the processor run and start control
package crs_pkg;

  // Scratchpad geometry: 256 words of 4 bits, 16 locations per I/O module
  localparam int SP_WORDS = 256;
  localparam int SP_ADDR_W = 8;
  localparam int SP_DATA_W = 4;
  localparam int GROUP_SIZE = 16;
  localparam int NUM_GROUPS = 16;
  localparam int GROUP_LSB = 4;

  // Data processing phase length in clock cycles
  localparam int DP_CYCLES = 64;

  // Supply monitor: voltage in millivolts, alarm threshold 4,75 V
  localparam int SUPPLY_W = 13;
  localparam logic [12:0] ALARM_MV = 13'h128e;

  // Tape reader word width (bits 1 to 7)
  localparam int TAPE_W = 7;

  // Reset values
  localparam logic [SP_DATA_W-1:0] SP_CLEAR = 4'h0;
  localparam logic [SP_ADDR_W-1:0] ADDR_ZERO = 8'h00;

  // Processor phase, Gray coded along held -> io -> drain -> dp -> held; dp -> io changes both bits
  typedef enum logic [1:0] {
    PH_HELD = 2'b00,
    PH_IO = 2'b01,
    PH_DRAIN = 2'b11,
    PH_DP = 2'b10
  } crs_phase_e;

endpackage

// [logic/crs_edge_sync.sv]
// Two-stage synchroniser with rising edge pulse for a slow level input
`timescale 1ns/1ps
module crs_edge_sync
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic levelIn,
  output logic levelSync,
  output logic risePulse
);

  logic stage1;
  logic stage2;

  // First stage feeds only the second stage; reset to the run level so a
  // switch already closed at release gives no false start edge
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
    end
    else
    begin
      stage1 <= levelIn;
      stage2 <= stage1;
    end
  end

  // Edge detect looks at the settled stage only
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      levelSync <= 1'b1;
      risePulse <= 1'b0;
    end
    else
    begin
      levelSync <= stage2;
      risePulse <= stage2 & ~levelSync;
    end
  end

endmodule

// [logic/crs_run_start_ctrl.sv]
// Run and start control of the central processor with I/O update cycle
// Behaviour
// - Active-low hold input from external switch stops the processor running.
// - Hold low keeps processor parked at start of an I/O cycle.
// - Hold rising starts running at the beginning of an I/O cycle.
// - Clear mode start zeroes every non-input scratchpad word in first I/O cycle.
// - Clear mode start leaves all outputs passive after first I/O cycle.
// - Keep mode start drives existing output words during first I/O cycle.
// - Alarm output goes low while supply is below 4,75 V.
// - Start block low makes the start input inoperative.
// - Controller alternates endlessly between I/O cycle and processing cycle.
// - Read inputs, process by program, transfer results to outputs.
// - Output clear low resets latches of its output modules.
// - Input ignore low drops input data and freezes its outputs unless a clear must land.
`timescale 1ns/1ps
module crs_run_start_ctrl
  import crs_pkg::*;
#(
  parameter int DP_LEN = DP_CYCLES,
  parameter logic [SUPPLY_W-1:0] ALARM_LEVEL = ALARM_MV
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cpuHoldN,
  input wire logic clearOnStartSel,
  input wire logic startReq,
  input wire logic startBlockN,
  input wire logic [NUM_GROUPS-1:0] inputGroupMap,
  input wire logic [NUM_GROUPS-1:0] inputIgnoreN,
  input wire logic [NUM_GROUPS-1:0] outputLatchClearN,
  input wire logic [SP_DATA_W-1:0] inData,
  input wire logic dpWrEn,
  input wire logic [SP_ADDR_W-1:0] dpAddr,
  input wire logic [SP_DATA_W-1:0] dpWrData,
  input wire logic [SUPPLY_W-1:0] supplyMv,
  input wire logic [TAPE_W-1:0] tapeBit,
  input wire logic tapeStrobe,
  input wire logic tapeSourceSel,
  input wire logic progEntry,
  output logic [SP_ADDR_W-1:0] ioAddr,
  output logic ioRead,
  output logic ioWrite,
  output logic [SP_DATA_W-1:0] ioWrData,
  output logic [SP_DATA_W-1:0] dpRdData,
  output logic [1:0] phase,
  output logic running,
  output logic firstCycle,
  output logic alarmN,
  output logic progBusyOut,
  output logic readerRunCtrl,
  output logic readerRunCtrlN,
  output logic [TAPE_W-1:0] tapeByte,
  output logic tapeByteValid
);

  // Refuse lengths the phase counter cannot hold
  if (DP_LEN < 1 || DP_LEN > 65535)
  begin : gBadLen
    $error("DP_LEN out of range");
  end

  // Scratchpad words
  logic [SP_DATA_W-1:0] spMem [SP_WORDS];

  crs_phase_e state;
  logic [SP_ADDR_W-1:0] ioIdx;
  logic [15:0] dpCnt;
  logic clearMode;
  logic holdSync;
  logic holdRise;
  logic rdPend;
  logic [SP_ADDR_W-1:0] rdAddr;
  logic startEvent;
  logic [NUM_GROUPS-1:0] groupIsIn;
  logic slotIsIn;
  logic slotLive;
  logic slotClear;
  logic [SP_DATA_W-1:0] slotOut;
  logic doSpClear;
  logic tapeStrobeDly;

  // Module group that owns a scratchpad address
  function automatic logic [GROUP_LSB-1:0] groupOf(input logic [SP_ADDR_W-1:0] addr);
    groupOf = addr[SP_ADDR_W-1:GROUP_LSB];
  endfunction

  // Hold switch is asynchronous to us, so it is resynchronised first
  crs_edge_sync uHoldSync
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .levelIn(cpuHoldN),
    .levelSync(holdSync),
    .risePulse(holdRise)
  );

  // Start on hold rising, or on a start request not blocked
  assign startEvent = holdRise
    | (startReq & startBlockN & holdSync);

  // Decode of the slot visited in this I/O step
  assign groupIsIn = inputGroupMap;
  assign slotIsIn = groupIsIn[groupOf(ioIdx)];
  assign slotLive = inputIgnoreN[groupOf(ioIdx)];
  assign slotClear = ~outputLatchClearN[groupOf(ioIdx)];
  assign doSpClear = firstCycle & clearMode & ~slotIsIn;

  // Output word: zero on clear start or latch reset, else stored value
  always_comb
  begin
    if (doSpClear || slotClear)
    begin
      slotOut = SP_CLEAR;
    end
    else
    begin
      slotOut = spMem[ioIdx];
    end
  end

  // Phase sequencer
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state <= PH_HELD;
    end
    else
    begin
      unique case (state)
        PH_HELD:
        begin
          if (startEvent)
          begin
            state <= PH_IO;
          end
        end
        PH_IO:
        begin
          if (ioIdx == SP_ADDR_W'(SP_WORDS - 1))
          begin
            state <= PH_DRAIN;
          end
        end
        PH_DRAIN:
        begin
          state <= PH_DP;
        end
        PH_DP:
        begin
          if (dpCnt == 16'(DP_LEN - 1))
          begin
            // Park at the head of the next I/O cycle while held
            state <= holdSync ? PH_IO : PH_HELD;
          end
        end
      endcase
    end
  end

  // Scan counters for both phases
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ioIdx <= ADDR_ZERO;
      dpCnt <= 16'h0000;
    end
    else
    begin
      if (state == PH_IO)
      begin
        ioIdx <= ioIdx + 8'h01;
      end
      else
      begin
        ioIdx <= ADDR_ZERO;
      end
      if (state == PH_DP)
      begin
        dpCnt <= dpCnt + 16'h0001;
      end
      else
      begin
        dpCnt <= 16'h0000;
      end
    end
  end

  // Start mode is sampled only on the start event itself
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      clearMode <= 1'b0;
      firstCycle <= 1'b0;
    end
    else
    begin
      if (state == PH_HELD && startEvent)
      begin
        clearMode <= clearOnStartSel;
        firstCycle <= 1'b1;
      end
      else if (state == PH_DRAIN)
      begin
        firstCycle <= 1'b0;
      end
    end
  end

  // I/O bus strobes, one slot per cycle, all registered
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ioAddr <= ADDR_ZERO;
      ioRead <= 1'b0;
      ioWrite <= 1'b0;
      ioWrData <= SP_CLEAR;
    end
    else
    begin
      ioAddr <= ioIdx;
      // Ignored input modules are simply not read
      ioRead <= (state == PH_IO) & slotIsIn & slotLive;
      // Frozen outputs skip the write unless a clear must land
      ioWrite <= (state == PH_IO) & ~slotIsIn
        & (slotLive | doSpClear | slotClear);
      ioWrData <= slotOut;
    end
  end

  // Input data returns one cycle after the read strobe
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      rdPend <= 1'b0;
      rdAddr <= ADDR_ZERO;
    end
    else
    begin
      rdPend <= ioRead;
      rdAddr <= ioAddr;
    end
  end

  // Scratchpad writes; an input return lands two slots late, beside a clear
  // of another word, so each write stands alone and none is dropped
  always_ff @(posedge clk_sys)
  begin
    if (rdPend)
    begin
      spMem[rdAddr] <= inData;
    end
    if (state == PH_IO && doSpClear)
    begin
      spMem[ioIdx] <= SP_CLEAR;
    end
    if (state == PH_DP && dpWrEn)
    begin
      spMem[dpAddr] <= dpWrData;
    end
  end

  // Processing read port, one cycle latency
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      dpRdData <= SP_CLEAR;
    end
    else
    begin
      dpRdData <= spMem[dpAddr];
    end
  end

  // Status outputs
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      phase <= PH_HELD;
      running <= 1'b0;
    end
    else
    begin
      phase <= state;
      running <= (state != PH_HELD);
    end
  end

  // Supply monitor, no hysteresis: a noisy supply will chatter the alarm
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      alarmN <= 1'b1;
    end
    else
    begin
      alarmN <= ~(supplyMv < ALARM_LEVEL);
    end
  end

  // Program entry: reader runs only while busy and tape is selected
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      progBusyOut <= 1'b0;
      readerRunCtrl <= 1'b0;
      readerRunCtrlN <= 1'b1;
    end
    else
    begin
      progBusyOut <= progEntry;
      readerRunCtrl <= progEntry & ~tapeSourceSel;
      readerRunCtrlN <= ~(progEntry & ~tapeSourceSel);
    end
  end

  // Tape word captured on strobe rise when tape is the source
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      tapeStrobeDly <= 1'b0;
      tapeByte <= 7'h00;
      tapeByteValid <= 1'b0;
    end
    else
    begin
      tapeStrobeDly <= tapeStrobe;
      tapeByteValid <= 1'b0;
      if (tapeStrobe && !tapeStrobeDly && !tapeSourceSel && progEntry)
      begin
        tapeByte <= tapeBit;
        tapeByteValid <= 1'b1;
      end
    end
  end

endmodule

// [test/crs_run_start_ctrl_monitor.sv]
// Port checker for the run and start control
`timescale 1ns/1ps
module crs_rsc_monitor
  import crs_pkg::*;
#(
  parameter logic [SUPPLY_W-1:0] ALARM_LEVEL = ALARM_MV
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cpuHoldN,
  input wire logic [NUM_GROUPS-1:0] inputGroupMap,
  input wire logic [NUM_GROUPS-1:0] inputIgnoreN,
  input wire logic [NUM_GROUPS-1:0] outputLatchClearN,
  input wire logic [SUPPLY_W-1:0] supplyMv,
  input wire logic tapeSourceSel,
  input wire logic progEntry,
  input wire logic [SP_ADDR_W-1:0] ioAddr,
  input wire logic ioRead,
  input wire logic ioWrite,
  input wire logic [SP_DATA_W-1:0] ioWrData,
  input wire logic [1:0] phase,
  input wire logic running,
  input wire logic alarmN,
  input wire logic progBusyOut,
  input wire logic readerRunCtrl,
  input wire logic readerRunCtrlN,
  input wire logic tapeByteValid
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  held_quiet_a: assert property (!$past(running, 2) && !running |-> phase == 2'b00 && !ioWrite)
    else $error("activity while held");
  start_on_rise_a: assert property ($past(rstn, 4) && $rose(cpuHoldN) && !running |-> ##[2:6] running)
    else $error("no start after hold release");
  park_on_hold_a: assert property ($fell(cpuHoldN) |-> ##[1:600] !running)
    else $error("hold did not stop the processor");
  alarm_level_a: assert property ($past(rstn) |-> alarmN == ($past(supplyMv) >= ALARM_LEVEL))
    else $error("alarm level wrong");
  reader_ctrl_a: assert property ($past(rstn) |-> readerRunCtrl == ($past(progEntry) && !$past(tapeSourceSel)) && readerRunCtrlN == !readerRunCtrl)
    else $error("reader control wrong");
  read_mapped_a: assert property (ioRead |-> inputGroupMap[ioAddr[7:4]] && inputIgnoreN[ioAddr[7:4]])
    else $error("read outside input group");
  write_output_a: assert property (ioWrite |-> !inputGroupMap[ioAddr[7:4]] && !ioRead)
    else $error("write to input group");
  clear_forces_zero_a: assert property (ioWrite && !outputLatchClearN[ioAddr[7:4]] |-> ioWrData == 4'h0)
    else $error("cleared group written nonzero");
  tape_pulse_a: assert property (tapeByteValid |=> !tapeByteValid)
    else $error("tape valid too long");
endmodule

bind crs_run_start_ctrl crs_rsc_monitor #(.ALARM_LEVEL(ALARM_LEVEL)) mon_u (.*);

// [test/crs_switch_reader.sv]
// Run switch and tape reader model at the far side of the block
`timescale 1ns/1ps
module crs_switch_reader
  import crs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic readerRunCtrl,
  output logic cpuHoldN,
  output logic [TAPE_W-1:0] tapeBit,
  output logic tapeStrobe,
  output logic tapeSourceSel
);
  // Switch closed to run; select line floats high by pull-up
  initial
  begin
    cpuHoldN = 1'b1;
    tapeBit = 7'h00;
    tapeStrobe = 1'b0;
    tapeSourceSel = 1'b1;
  end
  task automatic set_hold(input logic v);
    @(posedge clk_sys);
    #1 cpuHoldN = v;
  endtask
  task automatic set_source(input logic v);
    @(posedge clk_sys);
    #1 tapeSourceSel = v;
  endtask
  // Reader steps once its start/stop line is driven, or after 50 cycles without it
  task automatic send_byte(input logic [TAPE_W-1:0] b);
    int n;
    n = 0;
    @(posedge clk_sys);
    while (readerRunCtrl !== 1'b1 && n < 50)
    begin
      @(posedge clk_sys);
      n++;
    end
    #1 tapeBit = b;
    repeat (2) @(posedge clk_sys);
    #1 tapeStrobe = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 tapeStrobe = 1'b0;
    tapeBit = ~b; // Bits are not held once the strobe drops
  endtask
endmodule

// [test/crs_run_start_ctrl_tb.sv]
// Testbench for the run and start control
`timescale 1ns/1ps
module crs_run_start_ctrl_tb;
  import crs_pkg::*;
  logic clk_sys = 1'b0, rstn = 1'b0, clearOnStartSel = 1'b1, startReq = 1'b0, startBlockN = 1'b1;
  logic progEntry = 1'b0, dpWrEn = 1'b0, cpuHoldN, tapeStrobe, tapeSourceSel, ioRead, ioWrite;
  logic running, firstCycle, alarmN, progBusyOut, readerRunCtrl, readerRunCtrlN, tapeByteValid;
  logic [15:0] inputIgnoreN = 16'hffff, inputGroupMap = 16'h0001, outputLatchClearN = 16'hfff7;
  logic [7:0] dpAddr = 8'h00, ioAddr;
  logic [3:0] dpWrData = 4'ha, inData = 4'h7, ioWrData, dpRdData;
  logic [12:0] supplyMv = 13'h1388;
  logic [6:0] tapeBit, tapeByte, gotByte;
  logic [1:0] phase;
  logic wr [256];
  logic [3:0] wd [256];
  int num_errors = 0, num_checks = 0, n;

  // Short processing phase keeps the run brief
  crs_run_start_ctrl #(.DP_LEN(8)) dut_u (.clk_sys(clk_sys), .rstn(rstn), .cpuHoldN(cpuHoldN),
    .clearOnStartSel(clearOnStartSel), .startReq(startReq), .startBlockN(startBlockN),
    .inputGroupMap(inputGroupMap), .inputIgnoreN(inputIgnoreN),
    .outputLatchClearN(outputLatchClearN),
    .inData(inData), .dpWrEn(dpWrEn), .dpAddr(dpAddr), .dpWrData(dpWrData), .supplyMv(supplyMv),
    .tapeBit(tapeBit), .tapeStrobe(tapeStrobe), .tapeSourceSel(tapeSourceSel),
    .progEntry(progEntry), .ioAddr(ioAddr), .ioRead(ioRead), .ioWrite(ioWrite),
    .ioWrData(ioWrData), .dpRdData(dpRdData), .phase(phase), .running(running),
    .firstCycle(firstCycle), .alarmN(alarmN), .progBusyOut(progBusyOut),
    .readerRunCtrl(readerRunCtrl), .readerRunCtrlN(readerRunCtrlN), .tapeByte(tapeByte),
    .tapeByteValid(tapeByteValid));
  crs_switch_reader p_u (.clk_sys(clk_sys), .readerRunCtrl(readerRunCtrl), .cpuHoldN(cpuHoldN),
    .tapeBit(tapeBit), .tapeStrobe(tapeStrobe), .tapeSourceSel(tapeSourceSel));

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  // Record every output slot written and the captured tape word
  always @(posedge clk_sys)
  begin
    if (ioWrite === 1'b1)
    begin
      wr[ioAddr] = 1'b1;
      wd[ioAddr] = ioWrData;
    end
    if (tapeByteValid === 1'b1)
      gotByte = tapeByte;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_ph(input logic [1:0] p);
    int k;
    k = 0;
    while (phase !== p && k < 3000)
    begin
      step(1);
      k++;
    end
    chk(phase, p);
  endtask
  task automatic clr;
    for (int i = 0; i < 256; i++)
      wr[i] = 1'b0;
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial
  begin
    #500000;
    num_errors++;
    give_verdict();
  end

  initial
  begin
    step(5);
    rstn = 1'b1;
    supplyMv = 13'h128d;
    step(2);
    chk(alarmN, 1'b0);
    supplyMv = ALARM_MV;
    step(2);
    chk(alarmN, 1'b1);
    $display("alarm test done");
    progEntry = 1'b1;
    p_u.set_source(1'b0);
    step(2);
    chk({readerRunCtrl, readerRunCtrlN, progBusyOut}, 8'h05);
    p_u.send_byte(7'h55);
    step(2);
    chk(gotByte, 7'h55);
    p_u.set_source(1'b1);
    step(2);
    chk(readerRunCtrl, 1'b0);
    progEntry = 1'b0;
    $display("tape test done");
    startBlockN = 1'b0;
    startReq = 1'b1;
    step(20);
    chk(running, 1'b0);
    clr();
    startBlockN = 1'b1;
    step(1);
    startReq = 1'b0;
    wait_ph(2'b10);
    n = 0;
    for (int i = 16; i < 256; i++)
      if (wr[i] !== 1'b1 || wd[i] !== 4'h0)
        n++;
    chk(8'(n), 8'h00);
    chk(wr[3], 1'b0);
    // Fill one normal and one latch-cleared word, then read back an input
    dpWrEn = 1'b1;
    dpAddr = 8'h25;
    step(1);
    dpAddr = 8'h35;
    dpWrData = 4'h9;
    step(1);
    dpWrEn = 1'b0;
    dpAddr = 8'h03;
    step(2);
    chk(dpRdData, 4'h7);
    $display("clear start test done");
    p_u.set_hold(1'b0);
    wait_ph(2'b00);
    step(10);
    chk({running, phase}, 8'h00);
    $display("hold test done");
    clearOnStartSel = 1'b0;
    inputIgnoreN = 16'hfffd;
    inputGroupMap = 16'h0011;
    inData = 4'h2;
    clr();
    p_u.set_hold(1'b1);
    wait_ph(2'b01);
    chk(firstCycle, 1'b1);
    wait_ph(2'b10);
    chk(wd[8'h25], 4'ha);
    chk(wd[8'h35], 4'h0);
    chk(wr[8'h15], 1'b0);
    chk(wr[8'h35], 1'b1);
    chk(wr[8'h45], 1'b0);
    chk(dpRdData, 4'h2);
    wait_ph(2'b01);
    $display("keep start test done");
    give_verdict();
  end
endmodule
